/* scs_defs.svh */
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ==========================================================
// Register indices on the SPI link
`define SCS_CFG2_IDX 7'h06
`define SCS_STAT0_IDX 7'h08
`define SCS_MASK_IDX 7'h0c
`define SCS_CNT_BASE_IDX 7'h40

// ==========================================================
// Statistics counter bank
`define SCS_CNT_NUM 4
`define SCS_CNT_IDX_W 2
`define SCS_CNT_W 16

// ==========================================================
// switch_config_second fields
`define SCS_CFG_COR_BIT 6
`define SCS_CFG_CRCAPP_BIT 5
`define SCS_CFG_IFG_BIT 4
`define SCS_CFG_UNK_BIT 2
`define SCS_CFG_MSPD_LSB 0
`define SCS_CFG_MSPD_MSB 1
`define SCS_CFG2_RST 32'h0000_0000
`define SCS_CFG2_WMASK 32'h0000_0077

// ==========================================================
// status_flags_low fields
`define SCS_ST_CTRL_PROTECT_ERROR_BIT 12
`define SCS_ST_TXFCS_BIT 11
`define SCS_ST_STAMP_LSB 8
`define SCS_ST_STAMP_MSB 10
`define SCS_ST_PHY_BIT 7
`define SCS_ST_RSTDONE_BIT 6
`define SCS_ST_HDR_BIT 5
`define SCS_ST_LOSS_BIT 4
`define SCS_STAT0_RST 32'h0000_0040
`define SCS_STAT0_W1C 32'h0000_1f70

// ==========================================================
// Interrupt mask register
`define SCS_MASKABLE 32'h0000_1fb0
`define SCS_MASK_RST 32'h0000_1fb0

// ==========================================================
// Link framing, in SPI clock cycles (last index of each phase)
`define SCS_HDR_LAST 5'd7
`define SCS_TURN_LAST 5'd15
`define SCS_WORD_LAST 5'd31
`define SCS_RD_MISS 32'h0000_0000

`endif

/* scs_host_model.sv */
`timescale 1ns/100ps
// ==========================================================
// SPI host: header, turnaround, 32-bit words, 64 ns clock only in frames
module scs_host_model
   import scs_pkg::*;
(
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   scs_word_t wbuf [4];
   scs_word_t rbuf [4];

   // Idle bus: clock parked low, device deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // One frame; a multi-word read stays in one frame
   task automatic frame(input logic wr, input scs_addr_t idx, input int n);
      logic [7:0] hdr;
      int last;
      int j;
      hdr = {wr, idx};
      last = wr ? 39 + 32 * (n - 1) : 22 + 32 * n;
      #7 cs_n = 1'b0;
      for (int i = 0; i <= last; i++) begin
         j = i - 8;
         if (i < 8) begin
            mosi = hdr[7 - i];
         end else begin
            mosi = wr ? wbuf[j / 32][31 - j % 32] : i[0];
         end
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
         j = i - 23;
         if (!wr && j >= 0) begin
            rbuf[j / 32][31 - j % 32] = miso;
         end
      end
      #16 cs_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
endmodule

/* scs_link_if.sv */
`timescale 1ns/100ps
// ==========================================================
// Request and answer between SPI-clock logic and core logic
interface scs_link_if;
   import scs_pkg::*;
   logic req_tgl;
   logic req_wr;
   scs_addr_t req_addr;
   scs_word_t req_wdata;
   logic ack_tgl;
   scs_word_t ack_rdata;

   modport link (output req_tgl, output req_wr, output req_addr, output req_wdata,
                 input ack_tgl, input ack_rdata);
   modport core (input req_tgl, input req_wr, input req_addr, input req_wdata,
                 output ack_tgl, output ack_rdata);
endinterface

/* scs_pkg.sv */
package scs_pkg;
`include "scs_defs.svh"

   // ==========================================================
   // Shared types
   typedef enum logic [1:0] {
      st_hdr = 2'b00,
      st_turn = 2'b01,
      st_data = 2'b10
   } scs_link_state_t;

   typedef logic [31:0] scs_word_t;
   typedef logic [6:0] scs_addr_t;
   typedef logic [`SCS_CNT_W-1:0] scs_count_t;
endpackage

/* scs_spi_link.sv */
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_spi_link
   import scs_pkg::*;
(
   input wire logic sclk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   scs_link_if.link bus
);
   scs_link_state_t state, next_state;
   logic [4:0] bit_cnt, next_cnt;
   scs_word_t shin, next_shin, shout, next_shout;
   scs_addr_t addr, next_addr;
   logic wr, next_wr, next_miso, fetch;
   logic next_req_tgl, next_req_wr;
   scs_addr_t next_req_addr;
   scs_word_t next_req_wdata;
   logic ack_s1, ack_s2;
   logic frame_rst_n;

   // Frame state is cleared whenever chip select is high
   assign frame_rst_n = arst_n & ~cs_n;

   // ==========================================================
   // Header, turnaround and word phases
   always_comb begin
      next_state = state;
      next_cnt = bit_cnt + 5'd1;
      next_shin = {shin[30:0], mosi};
      next_shout = {shout[30:0], 1'b0};
      next_addr = addr;
      next_wr = wr;
      next_req_tgl = bus.req_tgl;
      next_req_wr = bus.req_wr;
      next_req_addr = bus.req_addr;
      next_req_wdata = bus.req_wdata;
      fetch = 1'b0;
      case (state)
         st_hdr: begin
            if (bit_cnt == `SCS_HDR_LAST) begin
               next_cnt = 5'd0;
               next_wr = next_shin[7];
               next_addr = next_shin[6:0];
               if (next_shin[7]) begin
                  next_state = st_data;
               end else begin
                  next_state = st_turn;
                  next_req_tgl = ~bus.req_tgl;
                  next_req_wr = 1'b0;
                  next_req_addr = next_shin[6:0];
               end
            end
         end
         st_turn: begin
            if (bit_cnt == `SCS_TURN_LAST) begin
               next_cnt = 5'd0;
               next_state = st_data;
               fetch = 1'b1;
            end
         end
         st_data: begin
            if (bit_cnt == `SCS_WORD_LAST) begin
               next_cnt = 5'd0;
               if (wr) begin
                  next_req_tgl = ~bus.req_tgl;
                  next_req_wr = 1'b1;
                  next_req_addr = addr;
                  next_req_wdata = next_shin;
                  next_addr = addr + 7'd1;
               end else begin
                  fetch = 1'b1;
               end
            end
         end
         default: begin
            next_state = st_hdr;
         end
      endcase
      // Load the answered word and ask ahead for the next address
      if (fetch) begin
         next_shout = (ack_s2 == bus.req_tgl) ? bus.ack_rdata : `SCS_RD_MISS;
         next_req_tgl = ~bus.req_tgl;
         next_req_wr = 1'b0;
         next_req_addr = addr + 7'd1;
         next_addr = addr + 7'd1;
      end
      next_miso = next_shout[31];
   end

   // Frame registers
   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state <= st_hdr;
         bit_cnt <= 5'd0;
         shin <= '0;
         shout <= '0;
         addr <= '0;
         wr <= 1'b0;
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_cnt;
         shin <= next_shin;
         shout <= next_shout;
         addr <= next_addr;
         wr <= next_wr;
         miso <= next_miso;
         miso_oe <= 1'b1;
      end
   end

   // Request words and answer synchroniser survive chip select
   always_ff @(posedge sclk or negedge arst_n) begin
      if (!arst_n) begin
         bus.req_tgl <= 1'b0;
         bus.req_wr <= 1'b0;
         bus.req_addr <= '0;
         bus.req_wdata <= '0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         bus.req_tgl <= next_req_tgl;
         bus.req_wr <= next_req_wr;
         bus.req_addr <= next_req_addr;
         bus.req_wdata <= next_req_wdata;
         ack_s1 <= bus.ack_tgl;
         ack_s2 <= ack_s1;
      end
   end
endmodule

/* scs_stat_counters.sv */
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_stat_counters
   import scs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clear_on_read,
   input wire logic [`SCS_CNT_NUM-1:0] count_event,
   input wire logic read_strobe,
   input wire logic [`SCS_CNT_IDX_W-1:0] read_idx,
   output scs_count_t read_value
);
   scs_count_t cnt [`SCS_CNT_NUM];
   scs_count_t next_cnt [`SCS_CNT_NUM];

   // Count one event: saturate or wrap at the top
   function automatic scs_count_t bump(input scs_count_t v, input logic ev, input logic sat);
      if (!ev) begin
         return v;
      end
      if (sat && v == '1) begin
         return v;
      end
      return v + 1'b1;
   endfunction

   // Read port
   assign read_value = cnt[read_idx];

   // Next counts, a read clears only in clear-on-read mode
   always_comb begin
      for (int i = 0; i < `SCS_CNT_NUM; i++) begin
         if (read_strobe && clear_on_read && read_idx == i[`SCS_CNT_IDX_W-1:0]) begin
            next_cnt[i] = bump('0, count_event[i], clear_on_read);
         end else begin
            next_cnt[i] = bump(cnt[i], count_event[i], clear_on_read);
         end
      end
   end

   // Counter storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `SCS_CNT_NUM; i++) begin
            cnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `SCS_CNT_NUM; i++) begin
            cnt[i] <= next_cnt[i];
         end
      end
   end
endmodule

/* scs_top.sv */
`timescale 1ns/100ps
`include "scs_defs.svh"
// ==========================================================
module scs_top
   import scs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic spi_protocol_std,
   input wire logic ctrl_protect_en,
   input wire logic hdr_parity_fail,
   input wire logic ctrl_protect_fail,
   input wire logic link_frame_loss,
   input wire logic tx_frame_end,
   input wire logic tx_fcs_ok,
   input wire logic [2:0] stamp_capture,
   input wire logic phy_irq_in,
   input wire logic [`SCS_CNT_NUM-1:0] stat_event,
   input wire logic port1_rx_frame_end,
   input wire logic port1_rx_gap_short,
   input wire logic port1_rx_unknown,
   output logic int_n,
   output logic counter_clear_on_read,
   output logic crc_append,
   output logic tx_fcs_check_en,
   output logic rx_crc_forward,
   output logic port1_admit_short_gap,
   output logic port1_unknown_to_host,
   output logic [1:0] mgmt_clock_rate_sel,
   output logic footer_ext_status,
   output logic port1_rx_reject,
   output logic host_fwd_low_prio
);
   // ==========================================================
   // Declarations
   scs_link_if link_bus();

   // Link handshake
   logic req_s1;
   logic req_s2;
   logic req_seen;
   logic take;
   logic take_wr;
   logic take_rd;
   scs_addr_t req_addr;
   scs_word_t req_wdata;
   logic next_ack_tgl;
   scs_word_t next_ack_rdata;

   // Register state
   scs_word_t switch_config_second;
   scs_word_t next_config;
   scs_word_t status_flags_low;
   scs_word_t next_status;
   scs_word_t irq_mask;
   scs_word_t next_mask;
   scs_word_t st_set;
   scs_word_t st_clr;
   logic phy_boot_pend;
   logic next_phy_boot_pend;

   // Counter port
   logic cnt_rd_strobe;
   scs_count_t cnt_value;

   // Next output values
   logic next_int_n;
   logic next_ext_status;
   logic next_rx_reject;
   logic next_fwd_low;

   // ==========================================================
   // Decode helpers

   // True when the index falls in the counter bank
   function automatic logic is_counter(input scs_addr_t a);
      return (a >> 2) == (`SCS_CNT_BASE_IDX >> 2);
   endfunction

   // Read value for an index, unmapped indices read zero
   function automatic scs_word_t read_word(input scs_addr_t a, input scs_word_t cfg_w,
                                           input scs_word_t st_w, input scs_word_t mask_w,
                                           input scs_count_t cv);
      case (a)
         `SCS_CFG2_IDX: begin
            return cfg_w;
         end
         `SCS_STAT0_IDX: begin
            return st_w;
         end
         `SCS_MASK_IDX: begin
            return mask_w;
         end
         default: begin
            return is_counter(a) ? scs_word_t'(cv) : '0;
         end
      endcase
   endfunction

   // ==========================================================
   // SPI link on its own clock
   scs_spi_link u_link (
      .sclk(spi_sclk),
      .arst_n(arst_n),
      .cs_n(spi_cs_n),
      .mosi(spi_mosi),
      .miso(spi_miso),
      .miso_oe(spi_miso_oe),
      .bus(link_bus.link)
   );

   // ==========================================================
   // Request crossing into the core clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end else begin
         req_s1 <= link_bus.req_tgl;
         req_s2 <= req_s1;
      end
   end

   // Address and data stay still while a toggle is in flight
   assign req_addr = link_bus.req_addr;
   assign req_wdata = link_bus.req_wdata;
   assign take = req_s2 ^ req_seen;
   assign take_wr = take & link_bus.req_wr;
   assign take_rd = take & ~link_bus.req_wr;
   assign cnt_rd_strobe = take_rd & is_counter(req_addr);

   // Answer to a read or write request
   always_comb begin
      next_ack_tgl = link_bus.ack_tgl;
      next_ack_rdata = link_bus.ack_rdata;
      // Writes are answered too, so the link keeps its toggles paired
      if (take) begin
         next_ack_tgl = ~link_bus.ack_tgl;
      end
      if (take_rd) begin
         next_ack_rdata = read_word(req_addr, switch_config_second, status_flags_low,
                                    irq_mask, cnt_value);
      end
   end

   // Answer registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req_seen <= 1'b0;
         link_bus.ack_tgl <= 1'b0;
         link_bus.ack_rdata <= '0;
      end else begin
         req_seen <= req_s2;
         link_bus.ack_tgl <= next_ack_tgl;
         link_bus.ack_rdata <= next_ack_rdata;
      end
   end

   // ==========================================================
   // Statistics counters
   scs_stat_counters u_counters (
      .clk(clk),
      .arst_n(arst_n),
      .clear_on_read(switch_config_second[`SCS_CFG_COR_BIT]),
      .count_event(stat_event),
      .read_strobe(cnt_rd_strobe),
      .read_idx(req_addr[`SCS_CNT_IDX_W-1:0]),
      .read_value(cnt_value)
   );

   // ==========================================================
   // Configuration and mask writes
   always_comb begin
      next_config = switch_config_second;
      next_mask = irq_mask;
      if (take_wr && req_addr == `SCS_CFG2_IDX) begin
         next_config = req_wdata & `SCS_CFG2_WMASK;
      end
      if (take_wr && req_addr == `SCS_MASK_IDX) begin
         next_mask = req_wdata & `SCS_MASKABLE;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         switch_config_second <= `SCS_CFG2_RST;
         irq_mask <= `SCS_MASK_RST;
      end else begin
         switch_config_second <= next_config;
         irq_mask <= next_mask;
      end
   end

   // ==========================================================
   // Status flags, a set in the clearing cycle wins
   always_comb begin
      // Set events
      st_set = '0;
      st_set[`SCS_ST_CTRL_PROTECT_ERROR_BIT] = ctrl_protect_fail & ctrl_protect_en & spi_protocol_std;
      st_set[`SCS_ST_TXFCS_BIT] = tx_frame_end & ~tx_fcs_ok &
                                  ~switch_config_second[`SCS_CFG_CRCAPP_BIT];
      st_set[`SCS_ST_STAMP_MSB:`SCS_ST_STAMP_LSB] = stamp_capture;
      st_set[`SCS_ST_HDR_BIT] = hdr_parity_fail & spi_protocol_std;
      st_set[`SCS_ST_LOSS_BIT] = link_frame_loss | st_set[`SCS_ST_CTRL_PROTECT_ERROR_BIT];
      // Host one-writes
      st_clr = '0;
      if (take_wr && req_addr == `SCS_STAT0_IDX) begin
         st_clr = req_wdata & `SCS_STAT0_W1C;
      end
      next_status = ((status_flags_low & ~st_clr) | st_set) &
                    `SCS_STAT0_W1C;
      next_status[`SCS_ST_PHY_BIT] = phy_irq_in | phy_boot_pend;
      // Boot pending ends at the first status read
      next_phy_boot_pend = phy_boot_pend;
      if (take_rd && req_addr == `SCS_STAT0_IDX) begin
         next_phy_boot_pend = 1'b0;
      end
   end

   // Status registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_flags_low <= `SCS_STAT0_RST;
         phy_boot_pend <= 1'b1;
      end else begin
         status_flags_low <= next_status;
         phy_boot_pend <= next_phy_boot_pend;
      end
   end

   // ==========================================================
   // Interrupt, footer and frame decisions
   always_comb begin
      next_int_n = ~(status_flags_low[`SCS_ST_RSTDONE_BIT] |
                     (|(status_flags_low & ~irq_mask & `SCS_MASKABLE)));
      next_ext_status = status_flags_low[`SCS_ST_RSTDONE_BIT];
      next_rx_reject = port1_rx_frame_end & port1_rx_gap_short &
                       ~switch_config_second[`SCS_CFG_IFG_BIT];
      next_fwd_low = port1_rx_unknown & switch_config_second[`SCS_CFG_UNK_BIT];
   end

   // Output registers; no path holds back a frame with a bad FCS
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Idle levels
         int_n <= 1'b1;
         counter_clear_on_read <= 1'b0;
         crc_append <= 1'b0;
         tx_fcs_check_en <= 1'b0;
         rx_crc_forward <= 1'b0;
         port1_admit_short_gap <= 1'b0;
         port1_unknown_to_host <= 1'b0;
         mgmt_clock_rate_sel <= 2'h0;
         footer_ext_status <= 1'b0;
         port1_rx_reject <= 1'b0;
         host_fwd_low_prio <= 1'b0;
      end else begin
         // Interrupt, copies of the configuration fields (FCS check enable inverted from CRC append), and receive CRC forward tied high
         int_n <= next_int_n;
         counter_clear_on_read <= switch_config_second[`SCS_CFG_COR_BIT];
         crc_append <= switch_config_second[`SCS_CFG_CRCAPP_BIT];
         tx_fcs_check_en <= ~switch_config_second[`SCS_CFG_CRCAPP_BIT];
         rx_crc_forward <= 1'b1;
         port1_admit_short_gap <= switch_config_second[`SCS_CFG_IFG_BIT];
         port1_unknown_to_host <= switch_config_second[`SCS_CFG_UNK_BIT];
         mgmt_clock_rate_sel <=
            switch_config_second[`SCS_CFG_MSPD_MSB:`SCS_CFG_MSPD_LSB];
         // Footer and frame decisions
         footer_ext_status <= next_ext_status;
         port1_rx_reject <= next_rx_reject;
         host_fwd_low_prio <= next_fwd_low;
      end
   end
endmodule

/* scs_top_checker.sv */
`timescale 1ns/100ps
// ==========================================================
// Port-level checks of the configuration and status block
module scs_top_checker
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic spi_cs_n,
   input wire logic port1_rx_frame_end,
   input wire logic port1_rx_gap_short,
   input wire logic port1_rx_unknown,
   input wire logic int_n,
   input wire logic crc_append,
   input wire logic tx_fcs_check_en,
   input wire logic rx_crc_forward,
   input wire logic port1_admit_short_gap,
   input wire logic port1_unknown_to_host,
   input wire logic footer_ext_status,
   input wire logic port1_rx_reject,
   input wire logic host_fwd_low_prio
);
   logic [3:0] since_cs;

   // Clocks since the host last held chip select low, saturating
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         since_cs <= 4'hf;
      end else begin
         since_cs <= !spi_cs_n ? 4'h0 : since_cs + {3'h0, since_cs != 4'hf};
      end
   end

   // ==========================================================
   // Sequences
   sequence s_live;
      $past(arst_n) && arst_n;
   endsequence
   sequence s_gap_frame;
      port1_rx_frame_end && port1_rx_gap_short;
   endsequence

   // ==========================================================
   // Assertions
   a_check_follows_append: assert property (
      @(posedge clk) disable iff (!arst_n) s_live |-> tx_fcs_check_en == !crc_append)
      else $error("fcs check enable not opposite to crc append");
   a_crc_kept_rx: assert property (
      @(posedge clk) disable iff (!arst_n) s_live |-> rx_crc_forward)
      else $error("receive crc not forwarded");
   a_gap_reject: assert property (
      @(posedge clk) disable iff (!arst_n)
      s_gap_frame |=> port1_rx_reject == !port1_admit_short_gap)
      else $error("short gap frame handled against config");
   a_gap_quiet: assert property (
      @(posedge clk) disable iff (!arst_n)
      !(port1_rx_frame_end && port1_rx_gap_short) |=> !port1_rx_reject)
      else $error("reject without short gap frame");
   a_unknown_forward: assert property (
      @(posedge clk) disable iff (!arst_n)
      port1_rx_unknown |=> host_fwd_low_prio == port1_unknown_to_host)
      else $error("unknown frame forwarding against config");
   a_unknown_quiet: assert property (
      @(posedge clk) disable iff (!arst_n) !port1_rx_unknown |=> !host_fwd_low_prio)
      else $error("low priority forward without unknown frame");
   a_done_irq: assert property (
      @(posedge clk) disable iff (!arst_n) footer_ext_status |-> !int_n)
      else $error("reset done pending but interrupt idle");
   a_done_host_clear: assert property (
      @(posedge clk) disable iff (!arst_n) $fell(footer_ext_status) |-> since_cs < 4'ha)
      else $error("reset done cleared without host write");
endmodule

bind scs_top scs_top_checker u_chk (.clk, .arst_n, .spi_cs_n, .port1_rx_frame_end,
   .port1_rx_gap_short, .port1_rx_unknown, .int_n, .crc_append, .tx_fcs_check_en,
   .rx_crc_forward, .port1_admit_short_gap, .port1_unknown_to_host, .footer_ext_status,
   .port1_rx_reject, .host_fwd_low_prio);

/* test_scs_top.sv */
`timescale 1ns/100ps
module test_scs_top
   import scs_pkg::*;
;
   logic clk, arst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic spi_protocol_std, ctrl_protect_en, hdr_parity_fail, ctrl_protect_fail;
   logic link_frame_loss, tx_frame_end, tx_fcs_ok, phy_irq_in;
   logic [2:0] stamp_capture;
   logic [3:0] stat_event;
   logic port1_rx_frame_end, port1_rx_gap_short, port1_rx_unknown, int_n;
   logic counter_clear_on_read, crc_append, tx_fcs_check_en, rx_crc_forward;
   logic port1_admit_short_gap, port1_unknown_to_host, footer_ext_status;
   logic port1_rx_reject, host_fwd_low_prio;
   logic [1:0] mgmt_clock_rate_sel;
   int failures;
   int cmp_count;

   scs_top u_scs_top (.clk, .arst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
      .spi_protocol_std, .ctrl_protect_en, .hdr_parity_fail, .ctrl_protect_fail,
      .link_frame_loss, .tx_frame_end, .tx_fcs_ok, .stamp_capture, .phy_irq_in, .stat_event,
      .port1_rx_frame_end, .port1_rx_gap_short, .port1_rx_unknown, .int_n,
      .counter_clear_on_read, .crc_append, .tx_fcs_check_en, .rx_crc_forward,
      .port1_admit_short_gap, .port1_unknown_to_host, .mgmt_clock_rate_sel,
      .footer_ext_status, .port1_rx_reject, .host_fwd_low_prio);
   scs_host_model u_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));

   // Core clock, 100 ns
   always #50 clk = ~clk;

   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input scs_addr_t a, input scs_word_t d);
      u_host.wbuf[0] = d;
      u_host.frame(1'b1, a, 1);
      repeat (4) @(negedge clk);
   endtask
   task automatic rdchk(input scs_addr_t a, input scs_word_t exp);
      u_host.frame(1'b0, a, 1);
      @(negedge clk);
      chk(u_host.rbuf[0], exp);
   endtask
   task automatic test_done();
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_boot();
      chk(int_n, 1'b0);
      chk(footer_ext_status, 1'b1);
      chk(rx_crc_forward, 1'b1);
      @(negedge clk);
      rdchk(7'h08, 32'h0000_00c0);
      rdchk(7'h08, 32'h0000_0040);
      rdchk(7'h06, 32'h0000_0000);
   endtask
   task automatic t_cfg();
      wr(7'h06, 32'hffff_ffff);
      rdchk(7'h06, 32'h0000_0077);
      chk({counter_clear_on_read, crc_append, tx_fcs_check_en, port1_admit_short_gap,
         port1_unknown_to_host, mgmt_clock_rate_sel}, 7'h6f);
      wr(7'h06, 32'h0000_0001);
      chk({crc_append, tx_fcs_check_en, mgmt_clock_rate_sel}, 4'h5);
      wr(7'h30, 32'h0000_00ff);
      rdchk(7'h30, 32'h0000_0000);
   endtask
   task automatic t_port1();
      wr(7'h06, 32'h0000_0000);
      chk(mgmt_clock_rate_sel, 2'h0);
      for (int k = 0; k < 2; k++) begin
         {port1_rx_frame_end, port1_rx_gap_short, port1_rx_unknown} = 3'h7;
         @(negedge clk);
         {port1_rx_frame_end, port1_rx_gap_short, port1_rx_unknown} = 3'h0;
         chk({port1_rx_reject, host_fwd_low_prio}, k ? 2'h1 : 2'h2);
         wr(7'h06, 32'h0000_0014);
      end
   endtask
   task automatic t_flags();
      {ctrl_protect_en, ctrl_protect_fail, hdr_parity_fail, link_frame_loss} = 4'hf;
      @(negedge clk);
      {ctrl_protect_fail, hdr_parity_fail, link_frame_loss} = 3'h0;
      {spi_protocol_std, ctrl_protect_en, tx_frame_end, tx_fcs_ok} = 4'hf;
      @(negedge clk);
      tx_frame_end = 1'b0;
      rdchk(7'h08, 32'h0000_0050);
      {tx_frame_end, tx_fcs_ok, stamp_capture} = 5'h17; // Bad host CRC
      {ctrl_protect_fail, hdr_parity_fail} = 2'h3;
      @(negedge clk);
      {tx_frame_end, stamp_capture, ctrl_protect_fail, hdr_parity_fail} = '0;
      rdchk(7'h08, 32'h0000_1f70);
      wr(7'h08, 32'h0000_0000);
      rdchk(7'h08, 32'h0000_1f70);
      wr(7'h08, 32'hffff_ffff);
      rdchk(7'h08, 32'h0000_0000);
      chk({footer_ext_status, int_n}, 2'h1);
   endtask
   task automatic t_phy();
      phy_irq_in = 1'b1;
      @(negedge clk);
      wr(7'h08, 32'h0000_0080);
      rdchk(7'h08, 32'h0000_0080);
      chk(int_n, 1'b1);
      // The host would now look up the source over the management path
      phy_irq_in = 1'b0;
   endtask
   task automatic t_count();
      stat_event = 4'h5;
      repeat (2) @(negedge clk);
      stat_event = 4'h3;
      repeat (3) @(negedge clk);
      stat_event = 4'h0;
      rdchk(7'h42, 32'h0000_0002);
      rdchk(7'h42, 32'h0000_0002);
      wr(7'h06, 32'h0000_0054);
      u_host.frame(1'b0, 7'h40, 2);
      chk(u_host.rbuf[0], 32'h0000_0005);
      chk(u_host.rbuf[1], 32'h0000_0003);
      @(negedge clk);
      rdchk(7'h42, 32'h0000_0000);
      stat_event = 4'h3;
      @(negedge clk);
      stat_event = 4'h0;
      rdchk(7'h40, 32'h0000_0001);
      rdchk(7'h41, 32'h0000_0000);
      stat_event = 4'h8;
      repeat (65537) @(negedge clk);
      stat_event = 4'h0;
      rdchk(7'h43, 32'h0000_ffff);
      rdchk(7'h43, 32'h0000_0000);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      {spi_protocol_std, ctrl_protect_en, hdr_parity_fail, ctrl_protect_fail} = '0;
      {link_frame_loss, tx_frame_end, tx_fcs_ok, phy_irq_in, stamp_capture, stat_event} = '0;
      {port1_rx_frame_end, port1_rx_gap_short, port1_rx_unknown} = '0;
      failures = 0;
      cmp_count = 0;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      t_boot();
      t_cfg();
      t_port1();
      t_flags();
      t_phy();
      t_count();
      test_done();
   end

   // Watchdog, well past the expected run time
   initial begin
      #9_000_000;
      failures++;
      test_done();
   end
endmodule
